// *** src/psk_map.vh ***
/*
  constants for the port-set, compare-skip and flag-test execution block:
  opcodes, register offsets, field positions, reset values and state codes.
  assumes: included by bare name from the design and verification files of this block.
*/
`ifndef PSK_MAP_VH
`define PSK_MAP_VH

// ==========================================================
// instruction words
`define PSK_OP_PORT_SET      10'h00A
`define PSK_OP_SEA_FIRST     10'h025
`define PSK_OP_SKIP_ACC_EQ_MEM_OP          10'h026
`define PSK_OP_FLAG_TEST     10'h038
`define PSK_IMM_PREFIX       6'h07
`define PSK_IMM_PREFIX_HI    9
`define PSK_IMM_PREFIX_LO    4
`define PSK_IMM_HI           3
`define PSK_IMM_LO           0

// ==========================================================
// output port
`define PSK_PORT_BITS        6
`define PSK_PORT_RESET       6'h00

// ==========================================================
// register map
`define PSK_ADDR_W           4
`define PSK_DATA_W           8
`define PSK_REG_CTRL         4'h0
`define PSK_REG_PORT         4'h1
`define PSK_REG_STATUS       4'h2
`define PSK_REG_MASK         4'h3
`define PSK_REG_FLAG         4'h4
`define PSK_CTRL_GATE_BIT    0
`define PSK_CTRL_RESET       1'h0
`define PSK_MASK_RESET       4'h0

// ==========================================================
// interrupt status layout
`define PSK_EV_BITS          4
`define PSK_EV_PORT_SET      0
`define PSK_EV_SKIP          1
`define PSK_EV_FLAG_RAISED   2
`define PSK_EV_FLAG_TAKEN    3

// ==========================================================
// sequencer states
`define PSK_ST_W             1
`define PSK_ST_IDLE          1'h0
`define PSK_ST_IMM           1'h1

`endif

// *** src/psk_index_decode.v ***
/*
  one-hot decode of the index register onto the output port bits.
  assumes: index values above the port width give an all-zero mask.
*/
`timescale 1ns/1ns
`default_nettype none
`include "psk_map.vh"

module psk_index_decode (
  input  wire [3:0]                  index_i,
  input  wire                        enable_i,
  output wire [`PSK_PORT_BITS-1:0]   set_mask_o
);

  // ==========================================================
  // per-bit match
  genvar g;
  generate
    for (g = 0; g < `PSK_PORT_BITS; g = g + 1) begin : g_bit
      // a genvar cannot be part-selected, so it is sized once here
      localparam [3:0] bit_index = g;
      assign set_mask_o[g] = enable_i & (index_i == bit_index);
    end
  endgenerate

endmodule
`default_nettype wire

// *** src/psk_irq_status.v ***
/*
  sticky event status with mask and a level interrupt output.
  assumes: clear_i is a read strobe of the status register; a set in the
  same cycle wins so no event is lost.
*/
`timescale 1ns/1ns
`default_nettype none
`include "psk_map.vh"

module psk_irq_status (
  input  wire                        clock_i,
  input  wire                        rst_i,
  input  wire [`PSK_EV_BITS-1:0]     event_i,
  input  wire                        clear_i,
  input  wire [`PSK_EV_BITS-1:0]     mask_i,
  output reg  [`PSK_EV_BITS-1:0]     status_o,
  output wire                        irq_o
);

  // ==========================================================
  // sticky bits
  genvar g;
  generate
    for (g = 0; g < `PSK_EV_BITS; g = g + 1) begin : g_ev
      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          status_o[g] <= 1'b0;
        end else if (event_i[g]) begin
          status_o[g] <= 1'b1;
        end else if (clear_i) begin
          status_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // mask bit high lets the event through
  assign irq_o = |(status_o & mask_i);

endmodule
`default_nettype wire

// *** src/psk_exec.v ***
/*
  execution of four instructions of a small 4-bit core: port bit set by
  index register, skip on accumulator equal immediate (two words), skip on
  accumulator equal pointed memory nibble, and external request flag test.
  assumes: the core presents one word per executed cycle with
  instr_valid_i, honours instr_suppress_o by not executing that word, and
  supplies accumulator, index register and the nibble at the data pointer.
  the carry flag is never touched here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "psk_map.vh"

// How it works
// - port-set op raises port bit indexed by register
// - immediate compare is two words, two cycles
// - skip next when accumulator equals immediate
// - unequal immediate compare runs next instruction
// - memory compare is one word, one cycle
// - skip next when accumulator equals pointed nibble
// - flag test is one word, carry untouched
// - gate clear: flag set skips and clears
// - gate bit set makes flag test a no-op
module psk_exec (
  input  wire                        clock_i,
  input  wire                        rst_i,
  // instruction stream
  input  wire                        instr_valid_i,
  input  wire [9:0]                  instr_i,
  input  wire [3:0]                  acc_i,
  input  wire [3:0]                  index_i,
  input  wire [3:0]                  pointed_memory_nibble_i,
  input  wire                        ext_irq_event_i,
  output wire                        instr_suppress_o,
  output reg                         skip_o,
  output reg                         busy_o,
  output reg  [`PSK_PORT_BITS-1:0]   port_o,
  output reg                         ext_irq_request_flag_o,
  // register port
  input  wire [`PSK_ADDR_W-1:0]      addr_i,
  input  wire [`PSK_DATA_W-1:0]      wdata_i,
  input  wire                        wr_i,
  input  wire                        rd_i,
  output reg  [`PSK_DATA_W-1:0]      rdata_o,
  output wire                        irq_o
);

  // ==========================================================
  // state
  reg  [`PSK_ST_W-1:0]               state;
  reg  [`PSK_ST_W-1:0]               next_state;
  reg                                skip_pending;
  reg                                next_skip_pending;
  reg                                skip_second;
  reg                                next_skip_second;
  reg                                next_skip;
  reg                                ext_irq_enable_bit;
  reg  [`PSK_EV_BITS-1:0]            irq_mask;
  wire [`PSK_EV_BITS-1:0]            irq_status;
  wire [`PSK_PORT_BITS-1:0]          port_set_mask;

  // ==========================================================
  // decode of the word in hand
  wire suppress = instr_valid_i & (skip_pending | skip_second);
  wire live     = instr_valid_i & ~suppress;
  wire in_idle  = (state == `PSK_ST_IDLE);
  wire op_port  = live & in_idle & (instr_i == `PSK_OP_PORT_SET);
  wire op_sea   = live & in_idle & (instr_i == `PSK_OP_SEA_FIRST);
  wire op_skip_acc_eq_mem_op  = live & in_idle & (instr_i == `PSK_OP_SKIP_ACC_EQ_MEM_OP);
  wire op_test  = live & in_idle & (instr_i == `PSK_OP_FLAG_TEST);
  wire imm_word = live & (state == `PSK_ST_IMM);
  wire imm_ok   = (instr_i[`PSK_IMM_PREFIX_HI:`PSK_IMM_PREFIX_LO] == `PSK_IMM_PREFIX);
  wire [3:0] imm_val = instr_i[`PSK_IMM_HI:`PSK_IMM_LO];

  wire imm_equal = imm_word & imm_ok & (acc_i == imm_val);
  wire mem_equal = op_skip_acc_eq_mem_op & (acc_i == pointed_memory_nibble_i);
  // the gate bit at 1 leaves the flag and the program flow alone
  wire flag_take = op_test & ~ext_irq_enable_bit & ext_irq_request_flag_o;

  assign instr_suppress_o = suppress;

  // ==========================================================
  // sequencer
  always @* begin
    next_state        = state;
    next_skip_pending = skip_pending;
    next_skip_second  = skip_second;
    next_skip         = 1'b0;
    case (state)
      `PSK_ST_IDLE: begin
        if (op_sea) begin
          next_state = `PSK_ST_IMM;
        end
      end
      `PSK_ST_IMM: begin
        if (imm_word) begin
          // wrong second word: treated as a non-matching compare
          next_state = `PSK_ST_IDLE;
        end
      end
      default: begin
        next_state = `PSK_ST_IDLE;
      end
    endcase
    if (instr_valid_i & skip_second) begin
      next_skip_second = 1'b0;
    end else if (instr_valid_i & skip_pending) begin
      next_skip_pending = 1'b0;
      // a skipped two-word compare drags its immediate word with it
      next_skip_second  = (instr_i == `PSK_OP_SEA_FIRST);
    end
    if (imm_equal | mem_equal | flag_take) begin
      next_skip_pending = 1'b1;
      next_skip         = 1'b1;
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state        <= `PSK_ST_IDLE;
      skip_pending <= 1'b0;
      skip_second  <= 1'b0;
      skip_o       <= 1'b0;
      busy_o       <= 1'b0;
    end else begin
      state        <= next_state;
      skip_pending <= next_skip_pending;
      skip_second  <= next_skip_second;
      skip_o       <= next_skip;
      busy_o       <= (next_state == `PSK_ST_IMM);
    end
  end

  // ==========================================================
  // output port latch
  psk_index_decode u_decode (
    .index_i    (index_i),
    .enable_i   (op_port),
    .set_mask_o (port_set_mask)
  );

  // index outside the port width sets nothing; the program avoids it
  wire port_wr = wr_i & (addr_i == `PSK_REG_PORT);
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      port_o <= `PSK_PORT_RESET;
    end else if (port_wr) begin
      // an instruction set in the same cycle still lands
      port_o <= wdata_i[`PSK_PORT_BITS-1:0] | port_set_mask;
    end else begin
      port_o <= port_o | port_set_mask;
    end
  end

  // ==========================================================
  // external request flag: a new request beats the test's clear
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ext_irq_request_flag_o <= 1'b0;
    end else if (ext_irq_event_i) begin
      ext_irq_request_flag_o <= 1'b1;
    end else if (flag_take) begin
      ext_irq_request_flag_o <= 1'b0;
    end
  end

  // ==========================================================
  // control and mask registers
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ext_irq_enable_bit <= `PSK_CTRL_RESET;
      irq_mask           <= `PSK_MASK_RESET;
    end else if (wr_i) begin
      if (addr_i == `PSK_REG_CTRL) begin
        ext_irq_enable_bit <= wdata_i[`PSK_CTRL_GATE_BIT];
      end
      if (addr_i == `PSK_REG_MASK) begin
        irq_mask <= wdata_i[`PSK_EV_BITS-1:0];
      end
    end
  end

  // ==========================================================
  // event status and interrupt
  wire [`PSK_EV_BITS-1:0] events;
  assign events[`PSK_EV_PORT_SET]    = op_port;
  assign events[`PSK_EV_SKIP]        = next_skip;
  assign events[`PSK_EV_FLAG_RAISED] = ext_irq_event_i & ~ext_irq_request_flag_o;
  assign events[`PSK_EV_FLAG_TAKEN]  = flag_take;

  wire status_rd = rd_i & (addr_i == `PSK_REG_STATUS);

  psk_irq_status u_status (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .event_i  (events),
    .clear_i  (status_rd),
    .mask_i   (irq_mask),
    .status_o (irq_status),
    .irq_o    (irq_o)
  );

  // ==========================================================
  // read data, one cycle after the strobe and only then
  reg [`PSK_DATA_W-1:0] next_rdata;
  always @* begin
    next_rdata = {`PSK_DATA_W{1'b0}};
    if (rd_i) begin
      case (addr_i)
        `PSK_REG_CTRL:   next_rdata = {{(`PSK_DATA_W-1){1'b0}}, ext_irq_enable_bit};
        `PSK_REG_PORT:   next_rdata = {{(`PSK_DATA_W-`PSK_PORT_BITS){1'b0}}, port_o};
        `PSK_REG_STATUS: next_rdata = {{(`PSK_DATA_W-`PSK_EV_BITS){1'b0}}, irq_status};
        `PSK_REG_MASK:   next_rdata = {{(`PSK_DATA_W-`PSK_EV_BITS){1'b0}}, irq_mask};
        `PSK_REG_FLAG:   next_rdata = {{(`PSK_DATA_W-1){1'b0}}, ext_irq_request_flag_o};
        default:         next_rdata = {`PSK_DATA_W{1'b0}};
      endcase
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= {`PSK_DATA_W{1'b0}};
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// *** verif/psk_exec_asserts.sv ***
/* checker for psk_exec: port set, compare skips, flag test, read port.
   assumes: bound to psk_exec; sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
`include "psk_map.vh"
module psk_exec_chk (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       instr_valid_i,
  input wire logic [9:0] instr_i,
  input wire logic [3:0] acc_i,
  input wire logic [3:0] index_i,
  input wire logic [3:0] pointed_memory_nibble_i,
  input wire logic       ext_irq_event_i,
  input wire logic       instr_suppress_o,
  input wire logic       skip_o,
  input wire logic       busy_o,
  input wire logic [5:0] port_o,
  input wire logic       ext_irq_request_flag_o,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       irq_o
);
  // ==========================================
  // helpers: gate bit mirrored from writes, as the checker cannot read it
  logic gate;
  wire logic go = instr_valid_i && !instr_suppress_o && !busy_o;
  wire logic eq = acc_i == pointed_memory_nibble_i;
  wire logic ft = go && instr_i == `PSK_OP_FLAG_TEST;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) gate <= 1'h0;
    else if (wr_i && addr_i == `PSK_REG_CTRL) gate <= wdata_i[0];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // assertions
  port_set_a: assert property (go && instr_i == `PSK_OP_PORT_SET && index_i <= 4'h5 && !wr_i
    |=> port_o == ($past(port_o) | (6'h01 << $past(index_i)))) else $error("port bit not set");
  imm_first_a: assert property (go && instr_i == `PSK_OP_SEA_FIRST |=> busy_o && !skip_o)
    else $error("first compare word not held");
  imm_skip_a: assert property (busy_o && instr_valid_i && instr_i[9:4] == `PSK_IMM_PREFIX
    && instr_i[3:0] == acc_i |=> skip_o && !busy_o) else $error("equal immediate not skipped");
  imm_noskip_a: assert property (busy_o && instr_valid_i && instr_i[3:0] != acc_i
    |=> !skip_o && !busy_o) else $error("unequal immediate skipped");
  mem_skip_a: assert property (go && instr_i == `PSK_OP_SKIP_ACC_EQ_MEM_OP |=> skip_o == $past(eq))
    else $error("memory compare skip wrong");
  flag_take_a: assert property (ft && !gate && ext_irq_request_flag_o && !ext_irq_event_i
    |=> skip_o && !ext_irq_request_flag_o) else $error("set flag not taken");
  flag_zero_a: assert property (ft && !ext_irq_request_flag_o |=> !skip_o)
    else $error("clear flag skipped");
  flag_nop_a: assert property (ft && gate && ext_irq_request_flag_o
    |=> !skip_o && ext_irq_request_flag_o) else $error("gated flag test acted");
  suppress_a: assert property (skip_o && instr_valid_i |-> instr_suppress_o)
    else $error("word after skip not suppressed");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
endmodule
bind psk_exec psk_exec_chk chk (.clock_i(clock_i), .rst_i(rst_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .acc_i(acc_i), .index_i(index_i),
  .pointed_memory_nibble_i(pointed_memory_nibble_i), .ext_irq_event_i(ext_irq_event_i),
  .instr_suppress_o(instr_suppress_o), .skip_o(skip_o), .busy_o(busy_o), .port_o(port_o),
  .ext_irq_request_flag_o(ext_irq_request_flag_o), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
`default_nettype wire

// *** verif/tb_top.sv ***
/* self-checking bench for psk_exec: instruction and register tasks.
   assumes: psk_map.vh on the include path; one 100 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
`include "psk_map.vh"
module tb_top;
  logic clock_i = 1'h0, rst_i = 1'h1, instr_valid_i = 1'h0, ext_irq_event_i = 1'h0;
  logic wr_i = 1'h0, rd_i = 1'h0;
  logic [9:0] instr_i = 10'h000;
  logic [3:0] acc_i = 4'h0, index_i = 4'h0, nib = 4'h0, addr_i = 4'h0, n, a;
  logic [7:0] wdata_i = 8'h00, d;
  logic [5:0] exp;
  wire logic sup, skip_o, busy_o, flag, irq_o;
  wire logic [5:0] port_o;
  wire logic [7:0] rdata_o;
  int error_cnt = 0, total_checks = 0;
  always #5 clock_i = ~clock_i;
  psk_exec uut (.clock_i(clock_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .acc_i(acc_i), .index_i(index_i), .pointed_memory_nibble_i(nib),
    .ext_irq_event_i(ext_irq_event_i), .instr_suppress_o(sup), .skip_o(skip_o),
    .busy_o(busy_o), .port_o(port_o), .ext_irq_request_flag_o(flag), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
  // ==========================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    total_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] v);
    @(posedge clock_i);
    addr_i <= ad;
    wdata_i <= v;
    wr_i <= 1'h1;
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just then
  task automatic rd(input logic [3:0] ad, output logic [7:0] v);
    @(posedge clock_i);
    addr_i <= ad;
    rd_i <= 1'h1;
    @(posedge clock_i);
    rd_i <= 1'h0;
    #1 v = rdata_o;
  endtask
  task automatic exec(input logic [9:0] w, input logic [3:0] ac, input logic [3:0] ix);
    @(posedge clock_i);
    instr_valid_i <= 1'h1;
    instr_i <= w;
    acc_i <= ac;
    index_i <= ix;
  endtask
  task automatic idle;
    @(posedge clock_i);
    instr_valid_i <= 1'h0;
    #1;
  endtask
  // the word after a compare: suppressed if skipped, else it sets port bit 2
  task automatic after_skip(input logic sk);
    exec(`PSK_OP_PORT_SET, 4'h0, 4'h2);
    #1 chk(8'(sup), 8'(sk));
    idle();
    chk(8'(port_o), sk ? 8'h00 : 8'h04);
    wr(`PSK_REG_PORT, 8'h00);
  endtask
  // ==========================================
  // tests
  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'h0;
    #1 chk({port_o, skip_o, busy_o}, 8'h00);
    wr(4'hF, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      rd((i == 5) ? 4'hF : 4'(i), d);
      chk(d, 8'h00);
    end
    exp = 6'h00;
    for (int i = 0; i < 6; i++) begin
      exec(`PSK_OP_PORT_SET, 4'h0, 4'(i));
      idle();
      exp[i] = 1'h1;
      chk(8'(port_o), 8'(exp));
    end
    rd(`PSK_REG_PORT, d);
    chk(d, 8'h3F);
    wr(`PSK_REG_PORT, 8'h00);
    exec(`PSK_OP_PORT_SET, 4'h0, 4'h6);
    idle();
    chk(8'(port_o), 8'h00);
    for (int k = 0; k < 6; k++) begin
      n = 4'(k * 3);
      a = k[0] ? n : ~n;
      exec(`PSK_OP_SEA_FIRST, a, 4'h0);
      idle();
      chk(8'(busy_o), 8'h01);
      exec({`PSK_IMM_PREFIX, n}, a, 4'h0);
      idle();
      chk({skip_o, busy_o}, 8'(k[0]) << 1);
      after_skip(k[0]);
    end
    for (int k = 0; k < 2; k++) begin
      nib <= k[0] ? 4'h9 : 4'h5;
      exec(`PSK_OP_SKIP_ACC_EQ_MEM_OP, 4'h9, 4'h0);
      idle();
      chk(8'(skip_o), 8'(k[0]));
      after_skip(k[0]);
    end
    // a skipped two-word compare must take its immediate word along
    exec(`PSK_OP_SKIP_ACC_EQ_MEM_OP, 4'h9, 4'h0);
    exec(`PSK_OP_SEA_FIRST, 4'h3, 4'h0);
    #1 chk(8'(sup), 8'h01);
    exec({`PSK_IMM_PREFIX, 4'h3}, 4'h3, 4'h0);
    #1 chk(8'(sup), 8'h01);
    after_skip(1'h0);
    @(posedge clock_i) ext_irq_event_i <= 1'h1;
    @(posedge clock_i) ext_irq_event_i <= 1'h0;
    rd(`PSK_REG_FLAG, d);
    chk(d, 8'h01);
    wr(`PSK_REG_CTRL, 8'h01);
    exec(`PSK_OP_FLAG_TEST, 4'h0, 4'h0);
    idle();
    chk({skip_o, flag}, 8'h01);
    after_skip(1'h0);
    wr(`PSK_REG_CTRL, 8'h00);
    for (int k = 0; k < 2; k++) begin
      exec(`PSK_OP_FLAG_TEST, 4'h0, 4'h0);
      idle();
      chk({skip_o, flag}, k ? 8'h00 : 8'h02);
      if (k == 0) after_skip(1'h1);
    end
    chk(8'(irq_o), 8'h00);
    wr(`PSK_REG_MASK, 8'h02);
    #1 chk(8'(irq_o), 8'h01);
    rd(`PSK_REG_STATUS, d);
    chk(8'(d[1]), 8'h01);
    @(posedge clock_i) #1 chk(8'(irq_o), 8'h00);
    close_out();
  end
  // the tests need well under a thousand cycles; ten times that means a hang
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
